/* File: inc/flash_bus_pkg.sv */
// Purpose: shared constants and types of the stacked flash pin interface
// Assumes: 16-bit word bus, up to three flash dies and two psram dies
// Notes:   pin groups travel as packed structs
package flash_bus_pkg;

    localparam int ADDR_PINS     = 26;
    localparam int DATA_BITS     = 16;
    localparam int FLASH_DIES    = 3;
    localparam int FLASH_OE_PINS = 2;
    localparam int PSRAM_DIES    = 2;
    localparam int DIE_IDX_BITS  = 2;
    localparam int WAIT_POL_BIT  = 10;
    localparam int DIE_MBIT_DEF  = 128;
    localparam int RESERVED_LOW  = 24;
    localparam int FETCH_LIMIT   = 12;

    typedef logic [ADDR_PINS-1:0] addr_type;
    typedef logic [DATA_BITS-1:0] data_type;

    localparam addr_type ADDR_RESET = 26'h0000000;
    localparam data_type DATA_RESET = 16'h0000;

    typedef struct packed {
        logic [FLASH_DIES-1:0]    flash_ce_n;
        logic [FLASH_OE_PINS-1:0] flash_oe_n;
        logic                     flash_we_n;
        logic                     addr_valid_n;
        logic                     write_protect_n;
        logic                     sram_select_low;
        logic                     sram_select_high;
        logic [PSRAM_DIES-1:0]    psram_cs_n;
        logic                     ram_oe_n;
        logic                     ram_we_n;
        addr_type                 addr;
        data_type                 data;
    } pin_in_type;

    // every die deselected, every strobe idle
    localparam pin_in_type PINS_IDLE = '{flash_ce_n: 3'h7, flash_oe_n: 2'h3,
        flash_we_n: 1'b1, addr_valid_n: 1'b1, write_protect_n: 1'b1,
        sram_select_low: 1'b1, sram_select_high: 1'b0, psram_cs_n: 2'h3,
        ram_oe_n: 1'b1, ram_we_n: 1'b1, addr: ADDR_RESET, data: DATA_RESET};

    typedef struct packed {
        logic [DIE_IDX_BITS-1:0] die;
        addr_type                addr;
        data_type                data;
    } cmd_type;

    typedef struct packed {
        logic                  sram_active;
        logic [PSRAM_DIES-1:0] psram_active;
        logic                  ram_read_en;
        logic                  ram_write_en;
    } ram_ctrl_type;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_FETCH,
        LINK_SHOW
    } link_phase_type;

    // highest word address pin used by a die of the given density
    function automatic int top_address_bit(input int mbit);
        case (mbit)
            256: return 23;
            128: return 22;
            64: return 21;
            32: return 20;
            8: return 18;
            default: return -1;
        endcase
    endfunction : top_address_bit

endpackage : flash_bus_pkg

/* File: hw/stacked_flash_bus_interface.sv */
// Purpose: pin-level host port of a stacked flash package (flash, sram, psram)
// Assumes: pins other than the link group are asynchronous to sys_clk;
//          bus_clk is the host's burst clock, ce/adv/addr are set up to it
// Notes:   word data for reads comes from the array port on sys_clk
`timescale 1ns/10ps

module stacked_flash_bus_interface
    import flash_bus_pkg::*;
#(
    parameter int                     DIE_MBIT    = flash_bus_pkg::DIE_MBIT_DEF,
    parameter flash_bus_pkg::data_type UNLOCK_CODE = 16'h00a5 // arbitrary value
) (
    // clocks and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    input  wire logic                         bus_clk,
    // package pins
    input  wire flash_bus_pkg::pin_in_type    pins,
    output logic     [flash_bus_pkg::DATA_BITS-1:0] dq_out,
    output logic                              dq_oe_n,
    output logic                              wait_out,
    output logic                              wait_oe_n,
    // configuration
    input  wire logic [flash_bus_pkg::DATA_BITS-1:0] read_config,
    input  wire logic                         sync_read_mode,
    // command interpreter
    output flash_bus_pkg::cmd_type            cmd,
    output logic                              cmd_valid,
    output logic                              cmd_refused,
    input  wire logic                         target_locked_down,
    // array read port
    output logic                              array_rd_en,
    output flash_bus_pkg::addr_type           array_rd_addr,
    output logic [flash_bus_pkg::DIE_IDX_BITS-1:0] array_rd_die,
    input  wire flash_bus_pkg::data_type      array_rd_data,
    // die activity
    output logic [flash_bus_pkg::FLASH_DIES-1:0] flash_active,
    output flash_bus_pkg::ram_ctrl_type       ram_ctrl
);
    import flash_bus_pkg::*;

    localparam int TOP_BIT = top_address_bit(DIE_MBIT);
    localparam logic [63:0] MASK_WIDE = (64'h1 << (TOP_BIT + 1)) - 64'h1;
    localparam addr_type ADDR_MASK = MASK_WIDE[ADDR_PINS-1:0];
    localparam int FETCH_BOUND = FETCH_LIMIT;

    generate
        if (TOP_BIT < 0 || TOP_BIT >= RESERVED_LOW) begin : g_bad_density
            $error("unsupported die density");
        end
    endgenerate

    typedef struct packed {
        pin_in_type             s1;
        pin_in_type             s2;
        pin_in_type             s3;
        pin_in_type             filt;
        logic                   we_n_prev;
        logic [FLASH_DIES-1:0]  sel_prev;
        addr_type               async_addr;
        data_type               async_data;
        cmd_type                cmd;
        logic                   cmd_valid;
        logic                   cmd_refused;
        logic                   req_s1;
        logic                   req_s2;
        logic                   req_seen;
        logic                   fetch_issue;
        logic                   fetch_cap;
        logic                   async_cap;
        logic                   ack_tog;
        data_type               xfer_data;
    } sys_state_type;

    typedef struct packed {
        logic                   rst_s1;
        logic                   rst_s2;
        logic                   mode_s1;
        logic                   mode_s2;
        logic                   ack_s1;
        logic                   ack_s2;
        logic                   ack_seen;
        logic                   req_tog;
        link_phase_type         state;
        addr_type               burst_addr;
        data_type               data;
    } link_state_type;

    localparam sys_state_type SYS_RESET = '{s1: PINS_IDLE, s2: PINS_IDLE,
        s3: PINS_IDLE, filt: PINS_IDLE, we_n_prev: 1'b1, default: '0};

    sys_state_type          sys_reg;
    sys_state_type          sys_next;
    link_state_type         link_reg;
    link_state_type         link_next;
    logic [FLASH_DIES-1:0]  flash_sel;
    logic [FLASH_DIES-1:0]  die_drive;
    logic                   flash_any;
    logic                   we_rise;
    logic                   refuse_now;
    logic                   async_read;
    logic                   link_sel;
    logic                   link_capture;
    logic                   wait_asserted;

    function automatic logic [DIE_IDX_BITS-1:0] die_index(
        input logic [FLASH_DIES-1:0] sel);
        logic [DIE_IDX_BITS-1:0] idx;
        idx = '0;
        for (int i = FLASH_DIES - 1; i >= 0; i--) begin
            if (sel[i]) begin
                idx = DIE_IDX_BITS'(i);
            end
        end
        return idx;
    endfunction : die_index

    assign flash_sel = ~sys_reg.filt.flash_ce_n;
    assign flash_any = |flash_sel;

    // output enable per die, die 0 on oe pin 0, dies 1 and 2 share oe pin 1, low enables
    generate
        for (genvar i = 0; i < FLASH_DIES; i++) begin : g_die
            localparam int OE_IDX = (i == 0) ? 0 : 1;
            assign die_drive[i] = flash_sel[i] & ~sys_reg.filt.flash_oe_n[OE_IDX];
        end
    endgenerate

    assign we_rise = ~sys_reg.we_n_prev & sys_reg.filt.flash_we_n & (|sys_reg.sel_prev);
    assign refuse_now = ~sys_reg.filt.write_protect_n & target_locked_down
                        & (sys_reg.filt.data == UNLOCK_CODE);
    assign async_read = flash_any & ~sync_read_mode & ~sys_reg.fetch_issue;

    always_comb begin
        logic [$bits(pin_in_type)-1:0] agree;
        agree = '0;
        sys_next = sys_reg;
        sys_next.s1 = pins;
        sys_next.s2 = sys_reg.s1;
        sys_next.s3 = sys_reg.s2;
        // a pin change counts once stages two and three agree
        agree = ~(sys_reg.s2 ^ sys_reg.s3);
        sys_next.filt = pin_in_type'((agree & sys_reg.s3) | (~agree & sys_reg.filt));
        sys_next.we_n_prev = sys_reg.filt.flash_we_n;
        sys_next.sel_prev = flash_sel;
        sys_next.cmd_valid = 1'b0;
        sys_next.cmd_refused = 1'b0;
        if (we_rise) begin
            sys_next.cmd.die = die_index(sys_reg.sel_prev);
            sys_next.cmd.addr = sys_reg.filt.addr & ADDR_MASK;
            sys_next.cmd.data = sys_reg.filt.data;
            sys_next.cmd_valid = ~refuse_now;
            sys_next.cmd_refused = refuse_now;
        end
        // flow-through while low, held after the rise
        if (!sys_reg.filt.addr_valid_n) begin
            sys_next.async_addr = sys_reg.filt.addr & ADDR_MASK;
        end
        // burst word requests from the link side
        sys_next.req_s1 = link_reg.req_tog;
        sys_next.req_s2 = sys_reg.req_s1;
        sys_next.fetch_issue = 1'b0;
        if (sys_reg.req_s2 != sys_reg.req_seen && !sys_reg.fetch_issue) begin
            sys_next.fetch_issue = 1'b1;
            sys_next.req_seen = sys_reg.req_s2;
        end
        sys_next.fetch_cap = sys_reg.fetch_issue;
        sys_next.async_cap = async_read;
        if (sys_reg.fetch_cap) begin
            sys_next.xfer_data = array_rd_data;
            sys_next.ack_tog = ~sys_reg.ack_tog;
        end
        if (sys_reg.async_cap) begin
            sys_next.async_data = array_rd_data;
        end
        if (rst) begin
            sys_next = SYS_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        sys_reg <= sys_next;
    end

    // link side: ce, adv and addr are set up to bus_clk by the host
    assign link_sel = ~&pins.flash_ce_n;
    // every bus clock edge with a flash die selected and address valid low, in sync mode
    assign link_capture = link_sel & ~pins.addr_valid_n & link_reg.mode_s2;

    always_comb begin
        link_next = link_reg;
        link_next.rst_s1 = rst;
        link_next.rst_s2 = link_reg.rst_s1;
        link_next.mode_s1 = sync_read_mode;
        link_next.mode_s2 = link_reg.mode_s1;
        link_next.ack_s1 = sys_reg.ack_tog;
        link_next.ack_s2 = link_reg.ack_s1;
        case (link_reg.state)
            LINK_IDLE: begin
                if (link_capture) begin
                    link_next.burst_addr = pins.addr & ADDR_MASK;
                    link_next.req_tog = ~link_reg.req_tog;
                    link_next.state = LINK_FETCH;
                end
            end
            LINK_FETCH: begin
                // address stays put until the word is back
                if (link_reg.ack_s2 != link_reg.ack_seen) begin
                    link_next.ack_seen = link_reg.ack_s2;
                    link_next.data = sys_reg.xfer_data;
                    link_next.state = link_sel ? LINK_SHOW : LINK_IDLE;
                end
            end
            LINK_SHOW: begin
                if (!link_sel || !link_reg.mode_s2) begin
                    link_next.state = LINK_IDLE;
                end else if (link_capture) begin
                    link_next.burst_addr = pins.addr & ADDR_MASK;
                    link_next.req_tog = ~link_reg.req_tog;
                    link_next.state = LINK_FETCH;
                end else begin
                    // burst counter advances on the valid edge
                    link_next.burst_addr = (link_reg.burst_addr + 26'h0000001) & ADDR_MASK;
                    link_next.req_tog = ~link_reg.req_tog;
                    link_next.state = LINK_FETCH;
                end
            end
            default: begin
                link_next.state = LINK_IDLE;
            end
        endcase
        if (link_reg.rst_s2) begin
            link_next.ack_seen = 1'b0;
            link_next.req_tog = 1'b0;
            link_next.state = LINK_IDLE;
            link_next.burst_addr = ADDR_RESET;
            link_next.data = DATA_RESET;
        end
    end

    always_ff @(posedge bus_clk) begin
        link_reg <= link_next;
    end

    // ready indicator, asserted = data not valid
    assign wait_asserted = ~sync_read_mode | ~sys_reg.filt.flash_we_n
                           | (link_reg.state != LINK_SHOW);
    assign wait_out = read_config[WAIT_POL_BIT] ? wait_asserted : ~wait_asserted;
    // float only on deselect, output enable not involved
    assign wait_oe_n = ~flash_any;

    // drive only for an enabled, selected die outside writes
    assign dq_oe_n = ~((|die_drive) & sys_reg.filt.flash_we_n);
    assign dq_out = sync_read_mode ? link_reg.data : sys_reg.async_data;

    assign cmd = sys_reg.cmd;
    assign cmd_valid = sys_reg.cmd_valid;
    assign cmd_refused = sys_reg.cmd_refused;
    assign array_rd_en = sys_reg.fetch_issue | async_read;
    assign array_rd_addr = sys_reg.fetch_issue ? link_reg.burst_addr : sys_reg.async_addr;
    assign array_rd_die = die_index(flash_sel);
    assign flash_active = flash_sel;

    always_comb begin
        ram_ctrl.sram_active = ~sys_reg.filt.sram_select_low & sys_reg.filt.sram_select_high;
        ram_ctrl.psram_active = ~sys_reg.filt.psram_cs_n;
        ram_ctrl.ram_read_en = (ram_ctrl.sram_active | (|ram_ctrl.psram_active))
                               & ~sys_reg.filt.ram_oe_n;
        ram_ctrl.ram_write_en = (ram_ctrl.sram_active | (|ram_ctrl.psram_active))
                                & ~sys_reg.filt.ram_we_n;
    end

    sequence write_edge_s;
        $rose(sys_reg.filt.flash_we_n) && (|sys_reg.sel_prev);
    endsequence

    sequence fetch_wait_s;
        link_reg.state == LINK_FETCH;
    endsequence

    wait_float_a: assert property (@(posedge sys_clk) disable iff (rst)
        !flash_any |-> wait_oe_n)
        else $error("ready indicator driven while deselected");

    wait_driven_a: assert property (@(posedge sys_clk) disable iff (rst)
        flash_any && (&sys_reg.filt.flash_oe_n) |-> !wait_oe_n)
        else $error("ready indicator floated by output enable");

    wait_polarity_a: assert property (@(posedge sys_clk) disable iff (rst)
        !sync_read_mode |-> wait_out == read_config[WAIT_POL_BIT])
        else $error("ready indicator not at asserted level");

    write_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
        write_edge_s ##0 !refuse_now |=> cmd_valid && !cmd_refused
            && cmd.data == $past(sys_reg.filt.data)
            && cmd.addr == ($past(sys_reg.filt.addr) & ADDR_MASK))
        else $error("write not captured at strobe rise");

    unlock_refused_a: assert property (@(posedge sys_clk) disable iff (rst)
        write_edge_s ##0 refuse_now |=> cmd_refused && !cmd_valid)
        else $error("lock-down unlock not refused");

    data_float_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!flash_any || (&sys_reg.filt.flash_oe_n)) |-> dq_oe_n)
        else $error("data bus driven while disabled");

    oe_split_a: assert property (@(posedge sys_clk) disable iff (rst)
        flash_sel == 3'h1 && sys_reg.filt.flash_oe_n == 2'h1 |-> dq_oe_n)
        else $error("die one gated by second output enable");

    addr_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        sys_reg.filt.addr_valid_n [*2] |=> $stable(sys_reg.async_addr))
        else $error("address moved after latch");

    addr_range_a: assert property (@(posedge sys_clk) disable iff (rst)
        (sys_reg.async_addr & ~ADDR_MASK) == ADDR_RESET)
        else $error("address above density top bit");

    sync_capture_a: assert property (@(posedge bus_clk) disable iff (link_reg.rst_s2)
        link_reg.state == LINK_IDLE && link_capture |=> link_reg.state == LINK_FETCH
            && link_reg.burst_addr == ($past(pins.addr) & ADDR_MASK))
        else $error("sync address not captured");

    burst_step_a: assert property (@(posedge bus_clk) disable iff (link_reg.rst_s2)
        link_reg.state == LINK_SHOW && link_sel && link_reg.mode_s2 && !link_capture
        |=> link_reg.burst_addr == (($past(link_reg.burst_addr) + 26'h0000001) & ADDR_MASK))
        else $error("burst counter did not advance");

    fetch_done_a: assert property (@(posedge bus_clk) disable iff (link_reg.rst_s2)
        fetch_wait_s |-> ##[1:FETCH_BOUND] link_reg.state != LINK_FETCH)
        else $error("burst word never became valid");

endmodule : stacked_flash_bus_interface

/* File: tb/host_model.sv */
// Purpose: host memory controller driving the package pins
// Assumes: pins change just after sys_clk rising edges
// Notes:   released data lines show the inverse of the last word
`timescale 1ns/10ps
module host_model
    import flash_bus_pkg::*;
(
    // clock
    input  wire logic                 sys_clk,
    // package pins
    output flash_bus_pkg::pin_in_type pins
);
    initial pins = PINS_IDLE;

    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : hold

    task automatic set_pins(input pin_in_type p);
        @(posedge sys_clk);
        pins <= p;
    endtask : set_pins

    task automatic write_word(input int die, input addr_type a, input data_type d,
                              input logic wp_n);
        pin_in_type p;
        p = PINS_IDLE;
        p.flash_ce_n[die] = 1'h0;
        p.addr = a;
        p.data = d;
        p.write_protect_n = wp_n;
        set_pins(p);
        hold(5);
        p.flash_we_n = 1'h0;
        set_pins(p);
        hold(5);
        p.flash_we_n = 1'h1;
        set_pins(p);
        hold(5);
        p = PINS_IDLE;
        p.data = ~d;
        set_pins(p);
    endtask : write_word
endmodule : host_model

/* File: tb/stacked_flash_bus_interface_bench.sv */
// Purpose: self-checking bench of the stacked flash pin port
// Assumes: density 128 Mbit, so word address bits 22:0 are kept
// Notes:   array model answers one sys_clk after a read request
`timescale 1ns/10ps
module stacked_flash_bus_interface_bench;
    import flash_bus_pkg::*;
    typedef struct packed {logic refused; cmd_type c;} note_type;
    localparam addr_type MASK   = 26'h07fffff;
    localparam data_type UNLOCK = 16'h00a5;
    logic         sys_clk = 1'h0;
    logic         bus_clk = 1'h0;
    logic         rst;
    pin_in_type   pins;
    pin_in_type   pv;
    data_type     dq_out;
    logic         dq_oe_n, wait_out, wait_oe_n, cmd_valid, cmd_refused, array_rd_en, pol;
    data_type     read_config;
    logic         sync_read_mode;
    logic         target_locked_down;
    cmd_type      cmd;
    addr_type     array_rd_addr;
    logic [1:0]   array_rd_die;
    data_type     array_rd_data;
    logic [2:0]   flash_active;
    ram_ctrl_type ram_ctrl;
    note_type     notes[$];
    note_type     nt;
    int           n_mismatch = 0;
    int           compares = 0;
    int           cycles = 0;

    always #5 sys_clk = ~sys_clk;
    initial begin
        #3.3;
        forever #16 bus_clk = ~bus_clk;
    end

    host_model host (.sys_clk(sys_clk), .pins(pins));

    stacked_flash_bus_interface #(.DIE_MBIT(128), .UNLOCK_CODE(UNLOCK)) dut (
        .sys_clk(sys_clk), .rst(rst), .bus_clk(bus_clk), .pins(pins),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .wait_out(wait_out), .wait_oe_n(wait_oe_n),
        .read_config(read_config), .sync_read_mode(sync_read_mode), .cmd(cmd),
        .cmd_valid(cmd_valid), .cmd_refused(cmd_refused),
        .target_locked_down(target_locked_down), .array_rd_en(array_rd_en),
        .array_rd_addr(array_rd_addr), .array_rd_die(array_rd_die),
        .array_rd_data(array_rd_data), .flash_active(flash_active), .ram_ctrl(ram_ctrl));

    function automatic data_type word_of(input addr_type a, input logic [1:0] d);
        return a[15:0] ^ {d, 4'h0, a[22:13]};
    endfunction : word_of

    always @(posedge sys_clk) begin
        if (array_rd_en === 1'h1) array_rd_data <= word_of(array_rd_addr, array_rd_die);
        else array_rd_data <= ~array_rd_data;
    end

    task automatic summarize();
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end else if (cmd_valid === 1'h1 || cmd_refused === 1'h1) begin
            if (notes.size() == 0) check(1'h1, 1'h0);
            else begin
                nt = notes.pop_front();
                check(cmd_refused, nt.refused);
                if (!nt.refused) check(cmd, nt.c);
            end
        end
    end

    task automatic apply(input pin_in_type p);
        host.set_pins(p);
        host.hold(8);
    endtask : apply

    task automatic do_write(input int die, input logic wp_n, input logic lk, input data_type d);
        addr_type a;
        a = 26'($urandom());
        target_locked_down <= lk;
        // top lines reserved, never relied on
        notes.push_back('{refused: !wp_n && d == UNLOCK && lk,
                          c: '{die: 2'(die), addr: a & MASK, data: d}});
        host.write_word(die, a, d, wp_n);
        host.hold(6);
    endtask : do_write

    task automatic wait_level(input logic lv);
        for (int i = 0; i < 400; i++) begin
            @(posedge sys_clk);
            #1;
            if (wait_out === lv) break;
        end
        check(wait_out, lv);
    endtask : wait_level

    task automatic async_read();
        addr_type a;
        a = 26'($urandom());
        sync_read_mode <= 1'h0;
        pv = PINS_IDLE;
        pv.flash_ce_n = 3'h6;
        pv.addr_valid_n = 1'h0;
        pv.addr = a;
        pv.flash_oe_n = 2'h2;
        apply(pv);
        check(dq_out, word_of(a & MASK, 2'h0));
        check({dq_oe_n, wait_oe_n, wait_out, flash_active}, {2'h0, pol, 3'h1});
        pv.flash_oe_n = 2'h3;
        apply(pv);
        check({dq_oe_n, wait_oe_n}, 2'h2);
        pv.flash_ce_n = 3'h5;
        pv.flash_oe_n = 2'h2;
        apply(pv);
        check({dq_oe_n, flash_active}, {1'h1, 3'h2});
        pv.flash_oe_n = 2'h1;
        pv.addr_valid_n = 1'h1;
        apply(pv);
        pv.addr = ~a;
        apply(pv);
        check({dq_oe_n, dq_out}, {1'h0, word_of(a & MASK, 2'h1)});
        pv.flash_ce_n = 3'h7;
        apply(pv);
        check({dq_oe_n, wait_oe_n}, 2'h3);
    endtask : async_read

    task automatic sync_read();
        addr_type a;
        a = 26'($urandom());
        sync_read_mode <= 1'h1;
        pv = PINS_IDLE;
        pv.flash_ce_n = 3'h6;
        pv.flash_oe_n = 2'h2;
        apply(pv);
        pv.addr_valid_n = 1'h0;
        pv.addr = a;
        host.set_pins(pv);
        host.hold(5);
        pv.addr_valid_n = 1'h1;
        host.set_pins(pv);
        for (int w = 0; w < 3; w++) begin
            wait_level(~pol);
            check(dq_out, word_of((a + 26'(w)) & MASK, 2'h0));
            wait_level(pol);
        end
        apply(PINS_IDLE);
    endtask : sync_read

    initial begin
        void'($urandom(59109));
        rst <= 1'h1;
        read_config <= 16'h0000;
        sync_read_mode <= 1'h0;
        target_locked_down <= 1'h0;
        host.hold(3);
        rst <= 1'h0;
        host.hold(2);
        for (int i = 0; i < 3; i++) do_write(i, 1'h1, 1'h0, 16'($urandom()) | 16'h0100);
        do_write(0, 1'h0, 1'h1, UNLOCK);
        do_write(1, 1'h1, 1'h1, UNLOCK);
        do_write(2, 1'h0, 1'h0, UNLOCK);
        for (int k = 0; k < 2; k++) begin
            pol = k[0];
            read_config <= (16'($urandom()) & 16'hfbff) | {5'h00, pol, 10'h000};
            async_read();
            sync_read();
        end
        pv = PINS_IDLE;
        pv.sram_select_low = 1'h0;
        pv.sram_select_high = 1'h1;
        pv.ram_oe_n = 1'h0;
        apply(pv);
        check({ram_ctrl, flash_active}, {1'h1, 2'h0, 1'h1, 1'h0, 3'h0});
        pv.sram_select_high = 1'h0;
        pv.psram_cs_n = 2'h2;
        pv.ram_oe_n = 1'h1;
        pv.ram_we_n = 1'h0;
        apply(pv);
        check(ram_ctrl, {1'h0, 2'h1, 1'h0, 1'h1});
        pv.psram_cs_n = 2'h1;
        apply(pv);
        check(ram_ctrl, {1'h0, 2'h2, 1'h0, 1'h1});
        check(notes.size(), 0);
        summarize();
    end
endmodule : stacked_flash_bus_interface_bench
